// >>> src/opaddr_map.vh
`ifndef OPADDR_MAP_VH
`define OPADDR_MAP_VH

// ****************************************
// Instruction word fields
// ****************************************
`define BYTE_BIT 15
`define SRC_HI 11
`define SRC_LO 6
`define DST_HI 5
`define DST_LO 0
`define DEFER_BIT 3

// ****************************************
// Addressing modes
// ****************************************
`define MODE_REG 3'h0
`define MODE_REG_DEF 3'h1
`define MODE_AUTOINC 3'h2
`define MODE_AUTOINC_DEF 3'h3
`define MODE_AUTODEC 3'h4
`define MODE_AUTODEC_DEF 3'h5
`define MODE_INDEX 3'h6
`define MODE_INDEX_DEF 3'h7

// ****************************************
// Dedicated registers
// ****************************************
`define REG_HARDWARE_STACK_POINTER 3'h6
`define REG_PROGRAM_COUNTER 3'h7

// ****************************************
// Pointer steps and reset values
// ****************************************
`define STEP_WORD 16'h0002
`define STEP_BYTE 16'h0001
`define GPR_RESET 16'h0000
`define BYTE_MASK_HI 8'h00

// ****************************************
// Operand kinds on the result port
// ****************************************
`define KIND_REG 2'h0
`define KIND_ADDR 2'h1
`define KIND_IMM 2'h2

`endif

// >>> src/operand_address_generator.v
`timescale 1ns/1ns
`include "opaddr_map.vh"

module operand_address_generator (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire start,
    output wire busy,
    output wire decode_req,
    output wire [15:0] instr_word,
    output wire byte_op,
    input wire src_en,
    input wire dst_en,
    output wire mem_rd,
    output wire [15:0] mem_addr,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    output wire opnd_valid,
    input wire opnd_ready,
    output wire opnd_is_dst,
    output wire [1:0] opnd_kind,
    output wire [2:0] opnd_reg,
    output wire [15:0] opnd_addr,
    output wire [15:0] opnd_data,
    output wire done,
    output wire wb_ready,
    input wire wb_en,
    input wire [2:0] wb_reg,
    input wire wb_byte,
    input wire [15:0] wb_data,
    input wire pc_load,
    input wire [15:0] pc_value,
    input wire [2:0] rd_sel,
    output wire [15:0] rd_data
);

    // ****************************************
    // States
    // ****************************************
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_DEC = 3'h2;
    localparam S_EVAL = 3'h3;
    localparam S_PTR = 3'h4;
    localparam S_IDX = 3'h5;
    localparam S_IND = 3'h6;
    localparam S_EMIT = 3'h7;

    // ****************************************
    // Storage
    // ****************************************
    reg [15:0] rf_r [0:7];
    reg [2:0] state_r;
    reg [15:0] instr_r;
    reg [5:0] spec_r;
    reg phase_r;
    reg dst_pend_r;
    reg done_r;
    reg mem_rd_r;
    reg [15:0] mem_addr_r;
    reg [1:0] kind_r;
    reg [2:0] reg_r;
    reg [15:0] addr_r;
    reg [15:0] data_r;
    integer i;

    wire [2:0] mode;
    wire [2:0] rsel;
    wire [15:0] rval;
    wire [15:0] pc;
    wire [15:0] pc_next;
    wire [15:0] rval_up;
    wire [15:0] rval_down;
    wire [15:0] index_sum;
    wire byte_w;

    assign mode = spec_r[5:3];
    assign rsel = spec_r[2:0];
    assign rval = rf_r[rsel];
    assign pc = rf_r[`REG_PROGRAM_COUNTER];
    assign pc_next = pc + `STEP_WORD;
    assign byte_w = instr_r[`BYTE_BIT];
    // Counter was advanced in the previous state, so the sum sees the new value
    assign index_sum = mem_rdata + rval;

    pointer_step u_step (
        .value(rval),
        .mode(mode),
        .reg_sel(rsel),
        .byte_op(byte_w),
        .value_up(rval_up),
        .value_down(rval_down)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign busy = (state_r != S_IDLE) | done_r;
    assign decode_req = (state_r == S_DEC);
    assign instr_word = instr_r;
    assign byte_op = byte_w;
    assign mem_rd = mem_rd_r;
    assign mem_addr = mem_addr_r;
    assign opnd_valid = (state_r == S_EMIT);
    assign opnd_is_dst = phase_r;
    assign opnd_kind = kind_r;
    assign opnd_reg = reg_r;
    assign opnd_addr = addr_r;
    assign opnd_data = data_r;
    assign done = done_r;
    // Write-back only while idle, so it never races a pointer update
    assign wb_ready = (state_r == S_IDLE) & ~start & ~done_r;
    assign rd_data = rf_r[rd_sel];

    // ****************************************
    // Sequencer and register file
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            for (i = 0; i < 8; i = i + 1) begin
                rf_r[i] <= `GPR_RESET;
            end
            state_r <= S_IDLE;
            instr_r <= 16'h0000;
            spec_r <= 6'h00;
            phase_r <= 1'b0;
            dst_pend_r <= 1'b0;
            done_r <= 1'b0;
            mem_rd_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            kind_r <= `KIND_REG;
            reg_r <= 3'h0;
            addr_r <= 16'h0000;
            data_r <= 16'h0000;
        end else if (ce) begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (done_r) begin
                        state_r <= S_IDLE;
                    end else if (start) begin
                        mem_addr_r <= pc;
                        mem_rd_r <= 1'b1;
                        state_r <= S_FETCH;
                    end else if (wb_en) begin
                        if (wb_byte) begin
                            rf_r[wb_reg][7:0] <= wb_data[7:0];
                        end else begin
                            rf_r[wb_reg] <= wb_data;
                        end
                    end else if (pc_load) begin
                        rf_r[`REG_PROGRAM_COUNTER] <= pc_value;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        instr_r <= mem_rdata;
                        rf_r[`REG_PROGRAM_COUNTER] <= pc_next;
                        mem_rd_r <= 1'b0;
                        state_r <= S_DEC;
                    end
                end
                S_DEC: begin
                    if (src_en) begin
                        spec_r <= instr_r[`SRC_HI:`SRC_LO];
                        phase_r <= 1'b0;
                        dst_pend_r <= dst_en;
                        state_r <= S_EVAL;
                    end else if (dst_en) begin
                        spec_r <= instr_r[`DST_HI:`DST_LO];
                        phase_r <= 1'b1;
                        dst_pend_r <= 1'b0;
                        state_r <= S_EVAL;
                    end else begin
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_EVAL: begin
                    reg_r <= rsel;
                    kind_r <= `KIND_ADDR;
                    data_r <= 16'h0000;
                    case (mode)
                        `MODE_REG: begin
                            kind_r <= `KIND_REG;
                            addr_r <= 16'h0000;
                            // Upper byte hidden for byte operations
                            data_r <= byte_w ? {`BYTE_MASK_HI, rval[7:0]} : rval;
                            state_r <= S_EMIT;
                        end
                        `MODE_REG_DEF: begin
                            addr_r <= rval;
                            state_r <= S_EMIT;
                        end
                        `MODE_AUTOINC: begin
                            rf_r[rsel] <= rval_up;
                            if (rsel == `REG_PROGRAM_COUNTER) begin
                                kind_r <= `KIND_IMM;
                                addr_r <= rval;
                                mem_addr_r <= rval;
                                mem_rd_r <= 1'b1;
                                state_r <= S_PTR;
                            end else begin
                                addr_r <= rval;
                                state_r <= S_EMIT;
                            end
                        end
                        `MODE_AUTOINC_DEF: begin
                            mem_addr_r <= rval;
                            mem_rd_r <= 1'b1;
                            rf_r[rsel] <= rval_up;
                            state_r <= S_PTR;
                        end
                        `MODE_AUTODEC: begin
                            rf_r[rsel] <= rval_down;
                            addr_r <= rval_down;
                            state_r <= S_EMIT;
                        end
                        `MODE_AUTODEC_DEF: begin
                            rf_r[rsel] <= rval_down;
                            mem_addr_r <= rval_down;
                            mem_rd_r <= 1'b1;
                            state_r <= S_PTR;
                        end
                        default: begin
                            // Index word sits at the counter; consume it first
                            mem_addr_r <= pc;
                            mem_rd_r <= 1'b1;
                            rf_r[`REG_PROGRAM_COUNTER] <= pc_next;
                            state_r <= S_IDX;
                        end
                    endcase
                end
                S_PTR: begin
                    if (mem_ack) begin
                        mem_rd_r <= 1'b0;
                        if (kind_r == `KIND_IMM) begin
                            data_r <= mem_rdata;
                        end else begin
                            addr_r <= mem_rdata;
                        end
                        state_r <= S_EMIT;
                    end
                end
                S_IDX: begin
                    if (mem_ack) begin
                        if (mode == `MODE_INDEX) begin
                            mem_rd_r <= 1'b0;
                            addr_r <= index_sum;
                            state_r <= S_EMIT;
                        end else begin
                            mem_addr_r <= index_sum;
                            state_r <= S_IND;
                        end
                    end
                end
                S_IND: begin
                    if (mem_ack) begin
                        mem_rd_r <= 1'b0;
                        addr_r <= mem_rdata;
                        state_r <= S_EMIT;
                    end
                end
                S_EMIT: begin
                    if (opnd_ready) begin
                        if (dst_pend_r) begin
                            // Destination sees every update made by the source
                            spec_r <= instr_r[`DST_HI:`DST_LO];
                            phase_r <= 1'b1;
                            dst_pend_r <= 1'b0;
                            state_r <= S_EVAL;
                        end else begin
                            done_r <= 1'b1;
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> src/pointer_step.v
`timescale 1ns/1ns
`include "opaddr_map.vh"

// Stepped pointer values for the auto modes; the stack pointer and the
// program counter must stay word aligned, so they never step by one.
module pointer_step (
    input wire [15:0] value,
    input wire [2:0] mode,
    input wire [2:0] reg_sel,
    input wire byte_op,
    output wire [15:0] value_up,
    output wire [15:0] value_down
);

    wire unit_step;
    wire [15:0] step;

    // Deferred forms always walk a table of word addresses
    assign unit_step = byte_op & ~mode[0] & (reg_sel < `REG_HARDWARE_STACK_POINTER);
    assign step = unit_step ? `STEP_BYTE : `STEP_WORD;
    assign value_up = value + step;
    assign value_down = value - step;

endmodule

// >>> verif/operand_address_generator_asserts.sv
`timescale 1ns/1ns
`include "opaddr_map.vh"
// ****
// Port checks for the operand address generator
// ****
module operand_address_generator_asserts (
    input wire clk,
    input wire reset,
    input wire start,
    input wire busy,
    input wire decode_req,
    input wire [15:0] instr_word,
    input wire byte_op,
    input wire mem_rd,
    input wire [15:0] mem_addr,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    input wire opnd_valid,
    input wire opnd_ready,
    input wire [1:0] opnd_kind,
    input wire [15:0] opnd_addr,
    input wire [15:0] opnd_data,
    input wire done,
    input wire wb_ready,
    input wire wb_en,
    input wire [2:0] wb_reg,
    input wire wb_byte,
    input wire [15:0] wb_data,
    input wire [2:0] rd_sel,
    input wire [15:0] rd_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    hold_read_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
        else $error("read request moved before its answer");
    fetch_decode_a: assert property (decode_req |-> $past(mem_ack) && $past(mem_rd)
        && !$past(decode_req) && instr_word == $past(mem_rdata)) else $error("bad decode step");
    byte_flag_a: assert property (decode_req |-> byte_op == instr_word[`BYTE_BIT])
        else $error("byte flag differs from instruction bit");
    byte_reg_a: assert property (opnd_valid && opnd_kind == `KIND_REG && byte_op
        |-> opnd_data[15:8] == `BYTE_MASK_HI) else $error("byte register operand has high bits");
    valid_hold_a: assert property (opnd_valid && !opnd_ready |=> opnd_valid
        && $stable(opnd_addr) && $stable(opnd_data) && $stable(opnd_kind))
        else $error("operand changed before acceptance");
    done_cause_a: assert property (done |-> (busy && ($past(decode_req)
        || $past(opnd_valid && opnd_ready))) ##1 (!done && !busy))
        else $error("done pulse without cause or too long");
    start_fetch_a: assert property (start && !busy && !done |=> busy && mem_rd)
        else $error("start did not fetch");
    idle_quiet_a: assert property (!busy |-> !mem_rd && !opnd_valid && !decode_req)
        else $error("activity while idle");
    reg_write_a: assert property ((wb_en && wb_ready && wb_reg == rd_sel)
        ##1 (rd_sel == $past(rd_sel)) |-> rd_data[7:0] == $past(wb_data[7:0])
        && rd_data[15:8] == ($past(wb_byte) ? $past(rd_data[15:8]) : $past(wb_data[15:8])))
        else $error("register write landed wrongly");
    cover property (opnd_valid && opnd_kind == `KIND_IMM);
    cover property (mem_ack ##1 mem_rd);
    cover property (wb_en && wb_ready && wb_byte);
    cover property (decode_req ##1 done);
endmodule

bind operand_address_generator operand_address_generator_asserts chk (.clk, .reset, .start,
    .busy, .decode_req, .instr_word, .byte_op, .mem_rd, .mem_addr, .mem_ack, .mem_rdata,
    .opnd_valid, .opnd_ready, .opnd_kind, .opnd_addr, .opnd_data, .done, .wb_ready, .wb_en,
    .wb_reg, .wb_byte, .wb_data, .rd_sel, .rd_data);

// >>> verif/operand_address_generator_bench.sv
`timescale 1ns/1ns
`include "opaddr_map.vh"
// ****
// Random instructions against a reference model
// ****
module operand_address_generator_bench;
    logic clk, reset, start, src_en, dst_en, opnd_ready, wb_en, wb_byte, pc_load;
    logic busy, decode_req, byte_op, mem_rd, mem_ack, opnd_valid, opnd_is_dst, done, wb_ready;
    logic [1:0] opnd_kind, lag;
    logic [2:0] opnd_reg, wb_reg, rd_sel;
    logic [15:0] instr_word, mem_addr, mem_rdata, opnd_addr, opnd_data;
    logic [15:0] wb_data, pc_value, rd_data;
    logic [15:0] regs [0:7];
    logic [37:0] exp_q [$];
    int num_errors, n_checks, guard;

    operand_address_generator dut (.clk, .reset, .ce(1'b1), .start, .busy, .decode_req,
        .instr_word, .byte_op, .src_en, .dst_en, .mem_rd, .mem_addr, .mem_ack, .mem_rdata,
        .opnd_valid, .opnd_ready, .opnd_is_dst, .opnd_kind, .opnd_reg, .opnd_addr, .opnd_data,
        .done, .wb_ready, .wb_en, .wb_reg, .wb_byte, .wb_data, .pc_load, .pc_value, .rd_sel,
        .rd_data);
    word_memory mem_u (.clk, .mem_rd, .mem_addr, .lag, .mem_ack, .mem_rdata);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task summarize;
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Which: 0 write port free, 1 decode step, 2 operand or done
    task wait_for(input int which);
        guard = 0;
        while (!(which == 0 ? wb_ready === 1'b1 : which == 1 ? decode_req === 1'b1
                : (opnd_valid === 1'b1 || done === 1'b1))) begin
            @(negedge clk);
            guard++;
            if (guard > 60) begin
                num_errors++;
                $display("wrong value wait %0d: expected 1, seen 0", which);
                summarize;
            end
        end
    endtask

    task put_reg(input logic [2:0] r, input logic [15:0] v, input logic b, input logic pcl);
        @(negedge clk);
        wait_for(0);
        rd_sel = r;
        wb_reg = r;
        wb_data = v;
        pc_value = v;
        wb_byte = b;
        wb_en = !pcl;
        pc_load = pcl;
        @(negedge clk);
        wb_en = 1'b0;
        pc_load = 1'b0;
        regs[r] = pcl ? v : b ? {regs[r][15:8], v[7:0]} : v;
        #1;
        check("rd_data", regs[r], rd_data);
    endtask

    task model_spec(input logic dst, input logic [5:0] s, input logic b);
        logic [2:0] m, r;
        logic [15:0] a, d;
        logic [1:0] k;
        m = s[5:3];
        r = s[2:0];
        k = `KIND_ADDR;
        d = 16'h0000;
        a = regs[r];
        if (m == `MODE_AUTODEC || m == `MODE_AUTODEC_DEF) begin
            regs[r] = regs[r] - ((m == `MODE_AUTODEC && b && r < 6) ? `STEP_BYTE : `STEP_WORD);
            a = regs[r];
        end else if (m == `MODE_AUTOINC || m == `MODE_AUTOINC_DEF) begin
            regs[r] = regs[r] + ((m == `MODE_AUTOINC && b && r < 6) ? `STEP_BYTE : `STEP_WORD);
        end else if (m >= `MODE_INDEX) begin
            d = mem_u.words[regs[7][15:1]];
            regs[7] = regs[7] + `STEP_WORD;
            a = d + regs[r];
        end
        if (m[0] && m != `MODE_REG_DEF)
            a = mem_u.words[a[15:1]];
        if (m == `MODE_REG) begin
            k = `KIND_REG;
            d = b ? {8'h00, regs[r][7:0]} : regs[r];
        end else if (m == `MODE_AUTOINC && r == `REG_PROGRAM_COUNTER) begin
            k = `KIND_IMM;
            d = mem_u.words[a[15:1]];
        end
        exp_q.push_back({dst, k, r, a, d});
    endtask

    task run_instr;
        logic [15:0] iw;
        logic [37:0] e;
        iw = 16'($urandom);
        lag = 2'($urandom);
        src_en = 1'($urandom);
        dst_en = 1'($urandom);
        mem_u.words[regs[7][15:1]] = iw;
        regs[7] = regs[7] + `STEP_WORD;
        if (src_en)
            model_spec(1'b0, iw[`SRC_HI:`SRC_LO], iw[`BYTE_BIT]);
        if (dst_en)
            model_spec(1'b1, iw[`DST_HI:`DST_LO], iw[`BYTE_BIT]);
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wait_for(1);
        check("instr_word", iw, instr_word);
        check("byte_op", {15'h0, iw[15]}, {15'h0, byte_op});
        wait_for(2);
        while (done !== 1'b1) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
            check("opnd_tag", {10'h0, e[37:32]}, {10'h0, opnd_is_dst, opnd_kind, opnd_reg});
            if (e[36:35] != `KIND_REG)
                check("opnd_addr", e[31:16], opnd_addr);
            if (e[36:35] != `KIND_ADDR)
                check("opnd_data", e[15:0], opnd_data);
            repeat ($urandom_range(2)) @(negedge clk);
            opnd_ready = 1'b1;
            @(negedge clk);
            opnd_ready = 1'b0;
            wait_for(2);
        end
        check("operands left", 16'h0000, 16'(exp_q.size()));
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            rd_sel = 3'(i);
            #1;
            check("register", regs[i], rd_data);
        end
    endtask

    initial begin
        {start, src_en, dst_en, opnd_ready, wb_en, wb_byte, pc_load} = 7'h00;
        {wb_reg, rd_sel, lag} = 8'h00;
        {wb_data, pc_value} = 32'h0000_0000;
        reset = 1'b1;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(32'h2120D0D1));
        for (int i = 0; i < 32768; i++)
            mem_u.words[i] = 16'($urandom);
        for (int i = 0; i < 8; i++)
            regs[i] = `GPR_RESET;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int n = 0; n < 150; n++) begin
            for (int r = 0; r < 7; r++)
                if ($urandom_range(1))
                    put_reg(3'(r), 16'($urandom), 1'($urandom), 1'b0);
            if (n % 3 == 0)
                put_reg(`REG_PROGRAM_COUNTER, 16'($urandom) & 16'hFFFE, 1'b0, 1'b1);
            run_instr;
        end
        summarize;
    end
endmodule

// >>> verif/word_memory.sv
`timescale 1ns/1ns
// ****
// Word memory behind the operand fetch port
// ****
module word_memory (
    input wire clk,
    input wire mem_rd,
    input wire [15:0] mem_addr,
    input wire [1:0] lag,
    output reg mem_ack,
    output reg [15:0] mem_rdata
);
    logic [15:0] words [0:32767];
    logic [1:0] cnt;
    logic answer;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        cnt = 2'h0;
    end
    assign answer = mem_rd && !mem_ack && cnt == lag;
    always @(posedge clk) begin
        mem_ack <= answer;
        // Toggles outside an answer so a stale sample never looks right
        mem_rdata <= answer ? words[mem_addr[15:1]] : ~mem_rdata;
        cnt <= (mem_rd && !mem_ack && !answer) ? cnt + 2'h1 : 2'h0;
    end
endmodule
